/* File: include/fpaf_pkg.sv */
// Package: operation codes, status layout, register map and widths for the arithmetic format block
package fpaf_pkg;
	localparam int WORD_W = 16;
	localparam int PROD_W = 32;
	localparam int MR_W = 40;
	localparam int FRAC_SHIFT = 1;

	// ALU operation select
	typedef enum logic [3:0] {
		FPAF_OP_ADD, FPAF_OP_ADDC, FPAF_OP_SUB, FPAF_OP_SUBB, FPAF_OP_RSUB, FPAF_OP_NEGX,
		FPAF_OP_INCY, FPAF_OP_DECY, FPAF_OP_PASSX, FPAF_OP_PASSY, FPAF_OP_AND, FPAF_OP_OR,
		FPAF_OP_XOR, FPAF_OP_NOTX, FPAF_OP_NOTY, FPAF_OP_ZERO
	} fpaf_aluop_e;

	// Multiplier operand types
	typedef enum logic [1:0] {
		FPAF_MUL_SS, FPAF_MUL_SU, FPAF_MUL_US, FPAF_MUL_UU
	} fpaf_multype_e;

	// Arith status bit positions
	localparam int ST_ZERO = 0;
	localparam int ST_NEG = 1;
	localparam int ST_OVF = 2;
	localparam int ST_CARRY = 3;
	localparam int ST_W = 4;

	// Interrupt event bit positions
	localparam int EV_OVF = 0;
	localparam int EV_CARRY = 1;
	localparam int EV_MULDONE = 2;
	localparam int EV_W = 3;

	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_EVENT = 4'h8;
	localparam logic [3:0] REG_MASK = 4'hC;
	localparam int ADDR_W = 4;

	localparam int CTRL_INTMODE = 0;
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : fpaf_pkg

/* File: verilog/fpaf_datapath.sv */
// ALU and multiplier number-format datapath with status capture and an Avalon-MM register slave
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps

// Contract
// - ALU operands and results are plain 16-bit patterns without sign handling.
// - Overflow and negative flags read the result as twos-complement signed.
// - Overflow set when result sign contradicts operand signs and operation.
// - Adding operands of opposite sign never sets overflow.
// - Carry flag is the unsigned carry out of the sixteenth bit.
// - NOT, AND, OR, XOR act bitwise on all sixteen bits.
// - Signed values are twos-complement only; no other signed encodings.
// - Low words of multiword arithmetic are handled as unsigned values.
// - Fractional format is one sign bit then fifteen fraction bits.
// - Multiplier treats each operand signed or unsigned as the instruction selects.
// - The 32-bit product is sign-extended across the 40-bit result register.
// - Fractional mode shifts the product left one bit before storing it.
// - Integer mode stores the product into the result register unshifted.
// - ALU status flags are captured into the status register the same cycle.
module fpaf_datapath #(
	parameter int WORD_W = fpaf_pkg::WORD_W,
	parameter int MR_W = fpaf_pkg::MR_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// ALU request from instruction decode
	input wire logic aluValid,
	input wire fpaf_pkg::fpaf_aluop_e aluOp,
	input wire logic [WORD_W-1:0] aluX,
	input wire logic [WORD_W-1:0] aluY,
	// ALU answer
	output logic [WORD_W-1:0] aluResult_q,
	output logic [fpaf_pkg::ST_W-1:0] arithStatusReg_q,
	// Multiply request
	input wire logic mulValid,
	input wire fpaf_pkg::fpaf_multype_e mulType,
	input wire logic mulRound,
	input wire logic [WORD_W-1:0] mulX,
	input wire logic [WORD_W-1:0] mulY,
	// Multiply answer
	output logic [MR_W-1:0] multiplyResultReg_q,
	// Avalon-MM slave
	input wire logic [fpaf_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata_q,
	output logic avsWaitrequest_q,
	// Interrupt
	output logic irq_q
);
	localparam int PW = 2 * WORD_W;
	localparam logic [WORD_W-1:0] ONE = 16'h0001;
	localparam logic [WORD_W-1:0] ROUND_BIT = 16'h8000;

	// ALU operand preparation; the adder works on raw bit patterns
	logic [WORD_W-1:0] addA;
	logic [WORD_W-1:0] addB;
	logic addCin;
	logic isLogic;
	logic [WORD_W-1:0] logicRes;
	logic carryFlagNow;

	assign carryFlagNow = arithStatusReg_q[fpaf_pkg::ST_CARRY];

	always_comb begin
		addA = aluX;
		addB = aluY;
		addCin = 1'b0;
		isLogic = 1'b0;
		logicRes = '0;
		unique case (aluOp)
			fpaf_pkg::FPAF_OP_ADD: begin
				addCin = 1'b0;
			end
			fpaf_pkg::FPAF_OP_ADDC: begin
				addCin = carryFlagNow;
			end
			fpaf_pkg::FPAF_OP_SUB: begin
				addB = ~aluY;
				addCin = 1'b1;
			end
			fpaf_pkg::FPAF_OP_SUBB: begin
				addB = ~aluY;
				addCin = carryFlagNow;
			end
			fpaf_pkg::FPAF_OP_RSUB: begin
				addA = aluY;
				addB = ~aluX;
				addCin = 1'b1;
			end
			fpaf_pkg::FPAF_OP_NEGX: begin
				addA = '0;
				addB = ~aluX;
				addCin = 1'b1;
			end
			fpaf_pkg::FPAF_OP_INCY: begin
				addA = aluY;
				addB = ONE;
			end
			fpaf_pkg::FPAF_OP_DECY: begin
				addA = aluY;
				addB = ~ONE;
				addCin = 1'b1;
			end
			fpaf_pkg::FPAF_OP_PASSX: begin
				addB = '0;
			end
			fpaf_pkg::FPAF_OP_PASSY: begin
				addA = aluY;
				addB = '0;
			end
			fpaf_pkg::FPAF_OP_AND: begin
				isLogic = 1'b1;
				logicRes = aluX & aluY;
			end
			fpaf_pkg::FPAF_OP_OR: begin
				isLogic = 1'b1;
				logicRes = aluX | aluY;
			end
			fpaf_pkg::FPAF_OP_XOR: begin
				isLogic = 1'b1;
				logicRes = aluX ^ aluY;
			end
			fpaf_pkg::FPAF_OP_NOTX: begin
				isLogic = 1'b1;
				logicRes = ~aluX;
			end
			fpaf_pkg::FPAF_OP_NOTY: begin
				isLogic = 1'b1;
				logicRes = ~aluY;
			end
			fpaf_pkg::FPAF_OP_ZERO: begin
				isLogic = 1'b1;
				logicRes = '0;
			end
		endcase
	end

	// Unsigned adder with carry out of the top bit
	logic [WORD_W:0] sumWide;
	logic [WORD_W-1:0] aluRes;
	logic sumOvf;
	logic [fpaf_pkg::ST_W-1:0] statusNow;

	assign sumWide = {1'b0, addA} + {1'b0, addB} + {{WORD_W{1'b0}}, addCin};
	assign aluRes = isLogic ? logicRes : sumWide[WORD_W-1:0];
	// Same operand signs, different result sign
	assign sumOvf = (addA[WORD_W-1] == addB[WORD_W-1]) && (sumWide[WORD_W-1] != addA[WORD_W-1]);
	assign statusNow[fpaf_pkg::ST_ZERO] = (aluRes == '0);
	assign statusNow[fpaf_pkg::ST_NEG] = aluRes[WORD_W-1];
	assign statusNow[fpaf_pkg::ST_OVF] = isLogic ? 1'b0 : sumOvf;
	assign statusNow[fpaf_pkg::ST_CARRY] = isLogic ? 1'b0 : sumWide[WORD_W];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			aluResult_q <= '0;
			arithStatusReg_q <= '0;
		end else if (aluValid) begin
			aluResult_q <= aluRes;
			arithStatusReg_q <= statusNow;
		end
	end

	// Multiplier: 17-bit signed extension per operand type
	logic xSigned;
	logic ySigned;
	logic signed [WORD_W:0] mulXe;
	logic signed [WORD_W:0] mulYe;
	logic signed [2*WORD_W+1:0] prodFull;
	logic [PW-1:0] prod;
	logic [PW-1:0] prodAdj;
	logic [PW-1:0] prodRnd;
	logic intMode_q;

	assign xSigned = (mulType == fpaf_pkg::FPAF_MUL_SS) || (mulType == fpaf_pkg::FPAF_MUL_SU);
	assign ySigned = (mulType == fpaf_pkg::FPAF_MUL_SS) || (mulType == fpaf_pkg::FPAF_MUL_US);
	assign mulXe = {xSigned & mulX[WORD_W-1], mulX};
	assign mulYe = {ySigned & mulY[WORD_W-1], mulY};
	assign prodFull = mulXe * mulYe;
	assign prod = prodFull[PW-1:0];
	// Fractional 2.30 becomes 1.31; integer stays 32.0
	assign prodAdj = intMode_q ? prod : (prod << fpaf_pkg::FRAC_SHIFT);
	assign prodRnd = mulRound ? (prodAdj + {{WORD_W{1'b0}}, ROUND_BIT}) : prodAdj;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			multiplyResultReg_q <= '0;
		end else if (mulValid) begin
			multiplyResultReg_q <= {{(MR_W-PW){prodRnd[PW-1]}}, prodRnd};
		end
	end

	// Register slave: one wait state, answers on the second edge
	logic [fpaf_pkg::EV_W-1:0] events_q;
	logic [fpaf_pkg::EV_W-1:0] mask_q;
	logic [fpaf_pkg::EV_W-1:0] evSet;
	logic [fpaf_pkg::EV_W-1:0] evClr;
	logic busReq;
	logic wrAccept;
	logic [fpaf_pkg::EV_W-1:0] eventsNext;
	logic [fpaf_pkg::EV_W-1:0] maskNext;
	logic ctrlHit;
	logic eventHit;
	logic maskHit;
	logic [31:0] readMux;

	assign busReq = avsRead | avsWrite;
	// Writes land on the edge that ends the transfer, when waitrequest is low
	assign wrAccept = avsWrite & ~avsWaitrequest_q;
	assign ctrlHit = (avsAddress == fpaf_pkg::REG_CTRL);
	assign eventHit = (avsAddress == fpaf_pkg::REG_EVENT);
	assign maskHit = (avsAddress == fpaf_pkg::REG_MASK);
	assign evSet[fpaf_pkg::EV_OVF] = aluValid & statusNow[fpaf_pkg::ST_OVF];
	assign evSet[fpaf_pkg::EV_CARRY] = aluValid & statusNow[fpaf_pkg::ST_CARRY];
	assign evSet[fpaf_pkg::EV_MULDONE] = mulValid;
	assign evClr = (wrAccept && eventHit && avsByteenable[0]) ? avsWritedata[fpaf_pkg::EV_W-1:0] : '0;
	assign maskNext = (wrAccept && maskHit && avsByteenable[0]) ? avsWritedata[fpaf_pkg::EV_W-1:0] : mask_q;
	assign eventsNext = (events_q & ~evClr) | evSet;

	always_comb begin
		unique case (avsAddress)
			fpaf_pkg::REG_CTRL: readMux = {31'h0000_0000, intMode_q};
			fpaf_pkg::REG_STATUS: readMux = {28'h000_0000, arithStatusReg_q};
			fpaf_pkg::REG_EVENT: readMux = {29'h0000_0000, events_q};
			fpaf_pkg::REG_MASK: readMux = {29'h0000_0000, mask_q};
			default: readMux = fpaf_pkg::UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			avsWaitrequest_q <= 1'b1;
			avsReaddata_q <= '0;
		end else begin
			avsWaitrequest_q <= ~(busReq & avsWaitrequest_q);
			if (avsRead & avsWaitrequest_q) begin
				avsReaddata_q <= readMux;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			intMode_q <= fpaf_pkg::CTRL_RESET;
			mask_q <= fpaf_pkg::MASK_RESET;
		end else begin
			mask_q <= maskNext;
			if (wrAccept && avsByteenable[0] && ctrlHit) begin
				intMode_q <= avsWritedata[fpaf_pkg::CTRL_INTMODE];
			end
		end
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			events_q <= '0;
			irq_q <= 1'b0;
		end else begin
			events_q <= eventsNext;
			irq_q <= |(eventsNext & maskNext);
		end
	end
endmodule : fpaf_datapath

/* File: bench/fpaf_asserts.sv */
// Checker: result, flag, product and bus-timing properties of the datapath
`timescale 1ns/1ps
module fpaf_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// ALU
	input wire logic aluValid,
	input wire fpaf_pkg::fpaf_aluop_e aluOp,
	input wire logic [15:0] aluX,
	input wire logic [15:0] aluY,
	input wire logic [15:0] aluResult_q,
	input wire logic [3:0] arithStatusReg_q,
	// Multiplier
	input wire logic mulValid,
	input wire fpaf_pkg::fpaf_multype_e mulType,
	input wire logic mulRound,
	input wire logic [15:0] mulX,
	input wire logic [15:0] mulY,
	input wire logic [39:0] multiplyResultReg_q,
	// Register bus
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	input wire logic avsWaitrequest_q
);
	logic intMode_q;
	logic addCarry;
	logic [15:0] addLow;
	logic ovfAdd;
	logic signed [39:0] prodSs;
	assign {addCarry, addLow} = {1'b0, aluX} + {1'b0, aluY};
	assign ovfAdd = (aluX[15] == aluY[15]) && (addLow[15] != aluX[15]);
	assign prodSs = $signed(mulX) * $signed(mulY);
	// Mirrors the mode bit so the product check knows which format applies
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) intMode_q <= 1'b0;
		else if (avsWrite && !avsWaitrequest_q && avsByteenable[0] && avsAddress == 4'h0) intMode_q <= avsWritedata[0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_add;
		aluValid && aluOp == fpaf_pkg::FPAF_OP_ADD;
	endsequence
	sequence s_mul_ss;
		mulValid && mulType == fpaf_pkg::FPAF_MUL_SS && !mulRound;
	endsequence
	add_result_a: assert property (s_add |=> aluResult_q == $past(addLow)) else $error("sum wrong");
	add_carry_a: assert property (s_add |=> arithStatusReg_q[3] == $past(addCarry)) else $error("carry wrong");
	add_ovf_a: assert property (s_add |=> arithStatusReg_q[2] == $past(ovfAdd)) else $error("ovf wrong");
	opp_sign_a: assert property (s_add ##0 (aluX[15] != aluY[15]) |=> !arithStatusReg_q[2])
		else $error("ovf on mixed signs");
	neg_flag_a: assert property (aluValid |=> arithStatusReg_q[1] == aluResult_q[15]) else $error("neg wrong");
	xor_bits_a: assert property (aluValid && aluOp == fpaf_pkg::FPAF_OP_XOR
		|=> aluResult_q == ($past(aluX) ^ $past(aluY))) else $error("xor wrong");
	mul_frac_a: assert property (s_mul_ss ##0 !intMode_q |=> multiplyResultReg_q == ($past(prodSs) <<< 1))
		else $error("frac product wrong");
	mul_int_a: assert property (s_mul_ss ##0 intMode_q |=> multiplyResultReg_q == $past(prodSs))
		else $error("int product wrong");
	bus_wait_a: assert property ((avsRead || avsWrite) && avsWaitrequest_q |=> !avsWaitrequest_q ##1 avsWaitrequest_q)
		else $error("wait state wrong");
endmodule : fpaf_asserts

bind fpaf_datapath fpaf_asserts fpaf_asserts_i (.mclk(mclk), .reset_n(reset_n), .aluValid(aluValid), .aluOp(aluOp),
	.aluX(aluX), .aluY(aluY), .aluResult_q(aluResult_q), .arithStatusReg_q(arithStatusReg_q), .mulValid(mulValid),
	.mulType(mulType), .mulRound(mulRound), .mulX(mulX), .mulY(mulY), .multiplyResultReg_q(multiplyResultReg_q),
	.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
	.avsByteenable(avsByteenable), .avsWaitrequest_q(avsWaitrequest_q));

/* File: bench/fpaf_core_model.sv */
// Instruction-decode side model issuing ALU and multiply requests
`timescale 1ns/1ps
module fpaf_core_model (
	// Clock
	input wire logic mclk,
	// ALU request
	output logic aluValid,
	output fpaf_pkg::fpaf_aluop_e aluOp,
	output logic [15:0] aluX,
	output logic [15:0] aluY,
	// Multiply request
	output logic mulValid,
	output fpaf_pkg::fpaf_multype_e mulType,
	output logic mulRound,
	output logic [15:0] mulX,
	output logic [15:0] mulY
);
	initial begin
		{aluValid, aluX, aluY, mulValid, mulRound, mulX, mulY} = 67'h0;
		aluOp = fpaf_pkg::FPAF_OP_ADD;
		mulType = fpaf_pkg::FPAF_MUL_SS;
	end
	task automatic alu(input logic [3:0] op, input logic [15:0] x, input logic [15:0] y);
		@(posedge mclk);
		aluValid <= 1'b1;
		aluOp <= fpaf_pkg::fpaf_aluop_e'(op);
		aluX <= x;
		aluY <= y;
		@(posedge mclk);
		aluValid <= 1'b0;
	endtask : alu
	task automatic mul(input logic [1:0] t, input logic r, input logic [15:0] x, input logic [15:0] y);
		@(posedge mclk);
		mulValid <= 1'b1;
		mulRound <= r;
		mulType <= fpaf_pkg::fpaf_multype_e'(t);
		mulX <= x;
		mulY <= y;
		@(posedge mclk);
		mulValid <= 1'b0;
	endtask : mul
endmodule : fpaf_core_model

/* File: bench/fixed_point_arith_formats_tb.sv */
// Testbench for the arithmetic format datapath
`timescale 1ns/1ps
module fixed_point_arith_formats_tb;
	typedef struct packed {logic [3:0] op; logic [15:0] x; logic [15:0] y; logic [15:0] r; logic [3:0] f;} fpaf_row_s;
	// Flags are {carry, overflow, negative, zero}
	localparam fpaf_row_s ROWS [20] = '{
		{4'h0, 16'h7FFF, 16'h0001, 16'h8000, 4'h6}, {4'h0, 16'h8000, 16'h7FFF, 16'hFFFF, 4'h2},
		{4'h0, 16'hFFFF, 16'h0001, 16'h0000, 4'h9}, {4'h1, 16'h0000, 16'h0000, 16'h0001, 4'h0},
		{4'h0, 16'h8000, 16'h8000, 16'h0000, 4'hD}, {4'h2, 16'h0000, 16'h0001, 16'hFFFF, 4'h2},
		{4'h2, 16'h8000, 16'h0001, 16'h7FFF, 4'hC}, {4'hA, 16'hFFFF, 16'h8001, 16'h8001, 4'h2},
		{4'hB, 16'h8000, 16'h0001, 16'h8001, 4'h2}, {4'hC, 16'hFFFF, 16'hFFFF, 16'h0000, 4'h1},
		{4'hD, 16'h0F0F, 16'h0000, 16'hF0F0, 4'h2}, {4'hE, 16'h0000, 16'h0000, 16'hFFFF, 4'h2},
		{4'h3, 16'h0005, 16'h0003, 16'h0001, 4'h8}, {4'h4, 16'h0001, 16'h0000, 16'hFFFF, 4'h2},
		{4'h5, 16'h8000, 16'h0000, 16'h8000, 4'h6}, {4'h6, 16'h0000, 16'hFFFF, 16'h0000, 4'h9},
		{4'h7, 16'h1234, 16'h0000, 16'hFFFF, 4'h2}, {4'h8, 16'h8000, 16'h0000, 16'h8000, 4'h2},
		{4'h9, 16'h0000, 16'h7FFF, 16'h7FFF, 4'h0}, {4'hF, 16'h1234, 16'h5678, 16'h0000, 4'h1}};
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic aluValid, mulValid, mulRound, avsWaitrequest_q, irq_q;
	fpaf_pkg::fpaf_aluop_e aluOp;
	fpaf_pkg::fpaf_multype_e mulType;
	logic [15:0] aluX, aluY, mulX, mulY, aluResult_q;
	logic [3:0] arithStatusReg_q;
	logic [3:0] avsAddress = 4'h0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata_q, rd;
	logic [39:0] multiplyResultReg_q;
	int miscompares = 0;
	int checkCount = 0;
	always #2.5 mclk = ~mclk;
	fpaf_core_model fpaf_core_model_i (.mclk, .aluValid, .aluOp, .aluX, .aluY, .mulValid, .mulType, .mulRound,
		.mulX, .mulY);
	fpaf_datapath fpaf_datapath_i (.mclk, .reset_n, .aluValid, .aluOp, .aluX, .aluY, .aluResult_q, .arithStatusReg_q,
		.mulValid, .mulType, .mulRound, .mulX, .mulY, .multiplyResultReg_q, .avsAddress, .avsRead, .avsWrite,
		.avsWritedata, .avsByteenable(4'hF), .avsReaddata_q, .avsWaitrequest_q, .irq_q);
	task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
		checkCount++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avsWrite <= w;
		avsRead <= !w;
		avsAddress <= a;
		avsWritedata <= d;
		do @(posedge mclk); while (avsWaitrequest_q !== 1'b0);
		q = avsReaddata_q;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask : bus
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		#20000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		repeat (16) @(posedge mclk);
		chk("wait in reset", avsWaitrequest_q, 1'b1);
		chk("product in reset", multiplyResultReg_q, 40'h0);
		reset_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0, rd);
		chk("mode reset", rd, 32'h0);
		foreach (ROWS[i]) begin
			fpaf_core_model_i.alu(ROWS[i].op, ROWS[i].x, ROWS[i].y);
			#1;
			chk("alu result", aluResult_q, ROWS[i].r);
			chk("alu flags", arithStatusReg_q, ROWS[i].f);
		end
		$display("alu table done");
		fpaf_core_model_i.mul(2'h0, 1'b0, 16'hFFFF, 16'h0001);
		#1 chk("frac ss", multiplyResultReg_q, 40'hFF_FFFF_FFFE);
		fpaf_core_model_i.mul(2'h1, 1'b0, 16'hFFFF, 16'hFFFF);
		#1 chk("frac su", multiplyResultReg_q, 40'hFF_FFFE_0002);
		bus(1'b1, 4'h0, 32'h1, rd);
		fpaf_core_model_i.mul(2'h0, 1'b0, 16'hFFFF, 16'h0001);
		#1 chk("int ss", multiplyResultReg_q, 40'hFF_FFFF_FFFF);
		fpaf_core_model_i.mul(2'h3, 1'b0, 16'h0002, 16'h0003);
		#1 chk("int uu", multiplyResultReg_q, 40'h00_0000_0006);
		fpaf_core_model_i.mul(2'h3, 1'b1, 16'h0002, 16'h0003);
		#1 chk("int uu rounded", multiplyResultReg_q, 40'h00_0000_8006);
		$display("multiply done");
		bus(1'b0, 4'h4, 32'h0, rd);
		chk("status read", rd, 32'h1);
		bus(1'b0, 4'h8, 32'h0, rd);
		chk("events", rd, 32'h7);
		chk("irq masked", irq_q, 1'b0);
		bus(1'b1, 4'hC, 32'h1, rd);
		#1 chk("irq raised", irq_q, 1'b1);
		bus(1'b1, 4'h8, 32'h7, rd);
		#1 chk("irq cleared", irq_q, 1'b0);
		bus(1'b0, 4'h2, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		$display("register tests done");
		fpaf_core_model_i.alu(4'h0, 16'h7FFF, 16'h0001);
		#1 chk("irq on overflow", irq_q, 1'b1);
		@(posedge mclk);
		reset_n <= 1'b0;
		@(posedge mclk);
		#1 chk("irq in reset", irq_q, 1'b0);
		chk("result in reset", aluResult_q, 16'h0000);
		chk("flags in reset", arithStatusReg_q, 4'h0);
		chk("product in mid reset", multiplyResultReg_q, 40'h0);
		chk("wait in mid reset", avsWaitrequest_q, 1'b1);
		@(posedge mclk);
		reset_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0, rd);
		chk("mode after reset", rd, 32'h0);
		bus(1'b0, 4'hC, 32'h0, rd);
		chk("mask after reset", rd, 32'h0);
		$display("reset tests done");
		report_and_stop;
	end
endmodule : fixed_point_arith_formats_tb
